/* File: logic/ccf_bit_sync.sv */
// two-flop synchroniser for one level into the mclk domain
`timescale 1ns/10ps
`default_nettype none
module ccf_bit_sync (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;

    // first flop feeds only the second
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

/* File: logic/ccf_channel_config.sv */
// channel 4 and channel 5 configuration frames: decode, storage, reply
// Function
// - top four bits carry command; code 0100 is the channel 4 frame
// - bit 27 clear stores and returns; set only returns configuration
// - command 4 bit 26 joins channels 1 to 4 as bridge one
// - bit 25 selects open-load masking report code for peak/hold group one
// - command 4 bit 24 enables peak and hold group one
// - bits 23:22 pick diag filter time; channel 4 ignores it in bridge timing
// - bit 21 returns programmed or compensated actual threshold on readout
// - bits 20:15 hold the six-bit overcurrent threshold code
// - bits 14:13 select temperature compensation range, 00 disables
// - bit 12 enables battery compensation of overcurrent detection
// - bits 11:9 select overcurrent blanking or no-failure assertion time
// - bit 8 selects re-engage on switching or on readout then switching
// - bridge mode always re-engages after readout; master clears latches
// - bit 7 selects drain-source or shunt overcurrent sensing
// - bit 6 selects 100 uA or 1 mA open-load regulator current
// - bits 5:4 select gate current: external, 20, 5, 1 mA
// - bit 2 low or high side; bit 3 N or P transistor
// - bit 1 enables the channel output
// - bit 0 is parity: one when other bits hold even ones
// - command 5 bits 26:25 set bridge two dead time 1 to 8 us
// - command 5 bit 24 clear shares channel 5 timer with channels 6 to 8 while bridge two is joined
// - bridge two without extended timers switches channel 5 field to bridge table
// - bridge two exists only when its join bit is set elsewhere
`timescale 1ns/10ps
`default_nettype none
module ccf_channel_config
    import ccf_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    // serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe_n,
    // settings held by other frames
    input wire logic bridge_one_timer_extend,
    input wire logic bridge_two_join,
    // compensated thresholds from the analog side
    input wire logic [ccf_pkg::THR_W-1:0] ch4_actual_threshold,
    input wire logic [ccf_pkg::THR_W-1:0] ch5_actual_threshold,
    // command 4 group settings
    output logic bridge_one_join,
    output logic peak_hold_one_mask_report,
    output logic peak_hold_one_enable,
    // channel 4 settings
    output logic [ccf_pkg::TWO_W-1:0] ch4_diag_filter,
    output logic ch4_diag_filter_used,
    output logic ch4_threshold_readback_select,
    output logic [ccf_pkg::THR_W-1:0] ch4_overcurrent_threshold,
    output logic [ccf_pkg::TWO_W-1:0] ch4_thermal_compensation,
    output logic ch4_supply_compensation,
    output logic [ccf_pkg::BLANK_W-1:0] ch4_overcurrent_blanking,
    output logic ch4_reengage_policy,
    output logic ch4_sense_method,
    output logic ch4_ol_current_high,
    output logic [ccf_pkg::TWO_W-1:0] ch4_gate_current,
    output logic ch4_pmos_select,
    output logic ch4_side_select,
    output logic ch4_out_enable,
    // command 5 bridge two settings
    output logic [ccf_pkg::TWO_W-1:0] bridge_two_deadband,
    output logic bridge_two_timer_extend,
    output logic ch5_diag_bridge_table,
    output logic ch6_8_share_ch5_timer,
    // channel 5 settings
    output logic [ccf_pkg::TWO_W-1:0] ch5_diag_filter,
    output logic ch5_threshold_readback_select,
    output logic [ccf_pkg::THR_W-1:0] ch5_overcurrent_threshold,
    output logic [ccf_pkg::TWO_W-1:0] ch5_thermal_compensation,
    output logic ch5_supply_compensation,
    output logic [ccf_pkg::BLANK_W-1:0] ch5_overcurrent_blanking,
    output logic ch5_reengage_policy,
    output logic ch5_sense_method,
    output logic ch5_ol_current_high,
    output logic [ccf_pkg::TWO_W-1:0] ch5_gate_current,
    output logic ch5_pmos_select,
    output logic ch5_side_select,
    output logic ch5_out_enable,
    // link status
    output logic comm_error,
    output logic frame_strobe
);
    import ccf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // link domain and crossing

    logic [FRAME_W-1:0] rx_word;
    logic link_full;
    logic full_sync;
    logic full_prev_q;
    logic frame_done;
    logic [FRAME_W-1:0] reply_q;

    ccf_spi_shift #(
        .FRAME_BITS(FRAME_W)
    ) u_shift (
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .reply_word(reply_q),
        .rx_word(rx_word),
        .frame_full(link_full),
        .miso_o(miso_o),
        .miso_oe_n(miso_oe_n)
    );

    ccf_bit_sync u_full_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(link_full),
        .sync_out(full_sync)
    );

    // rising edge of the synced done level marks one whole frame
    always_ff @(posedge mclk) begin
        if (sys_rst)
            full_prev_q <= 1'b0;
        else
            full_prev_q <= full_sync;
    end

    assign frame_done = full_sync & ~full_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // frame decode

    logic parity_ok;
    logic [3:0] cmd;
    logic is_out4;
    logic is_out5;
    logic write_req;

    assign parity_ok = ^rx_word;
    assign cmd = rx_word[CMD_HI:CMD_LO];
    assign is_out4 = (cmd == CCF_CMD_OUT4);
    assign is_out5 = (cmd == CCF_CMD_OUT5);
    assign write_req = ~rx_word[RW_BIT];

    ////////////////////////////////////////////////////////////////////////
    // stored frames

    logic [FRAME_W-1:0] cfg4_q;
    logic [FRAME_W-1:0] cfg5_q;
    logic err_q;
    logic strobe_q;

    // command 4 storage, only on a good write frame
    always_ff @(posedge mclk) begin
        if (sys_rst)
            cfg4_q <= CFG_RESET;
        else if (frame_done && parity_ok && is_out4 && write_req)
            cfg4_q[CFG_HI:CFG_LO] <= rx_word[CFG_HI:CFG_LO];
    end

    // command 5 storage, only on a good write frame
    always_ff @(posedge mclk) begin
        if (sys_rst)
            cfg5_q <= CFG_RESET;
        else if (frame_done && parity_ok && is_out5 && write_req)
            cfg5_q[CFG_HI:CFG_LO] <= rx_word[CFG_HI:CFG_LO];
    end

    // error flag tells the outcome of the last frame
    always_ff @(posedge mclk) begin
        if (sys_rst)
            err_q <= 1'b0;
        else if (frame_done)
            err_q <= ~parity_ok;
    end

    // one pulse per accepted or rejected frame
    always_ff @(posedge mclk) begin
        if (sys_rst)
            strobe_q <= 1'b0;
        else
            strobe_q <= frame_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // reply for the next frame

    logic [FRAME_W-1:0] rep4;
    logic [FRAME_W-1:0] rep5;
    logic [FRAME_W-1:0] rep_body;

    // threshold field shows programmed or compensated value
    always_comb begin
        rep4 = cfg4_q;
        rep5 = cfg5_q;
        // a write frame answers with the settings it stores, not the old ones
        if (is_out4 && write_req)
            rep4[CFG_HI:CFG_LO] = rx_word[CFG_HI:CFG_LO];
        if (is_out5 && write_req)
            rep5[CFG_HI:CFG_LO] = rx_word[CFG_HI:CFG_LO];
        if (rep4[RDSEL_BIT])
            rep4[THR_HI:THR_LO] = ch4_actual_threshold;
        if (rep5[RDSEL_BIT])
            rep5[THR_HI:THR_LO] = ch5_actual_threshold;
    end

    // reply carries the command and the error bit, new parity below
    always_comb begin
        rep_body = CFG_RESET;
        if (parity_ok && is_out4)
            rep_body = rep4;
        else if (parity_ok && is_out5)
            rep_body = rep5;
        rep_body[CMD_HI:CMD_LO] = parity_ok ? cmd : 4'h0;
        rep_body[RW_BIT] = ~parity_ok;
        rep_body[PAR_BIT] = 1'b0;
    end

    // reply word is held stable between frames for the link side
    always_ff @(posedge mclk) begin
        if (sys_rst)
            reply_q <= {CFG_RESET[FRAME_W-1:1], 1'b1};
        else if (frame_done)
            reply_q <= {rep_body[FRAME_W-1:1], ~^rep_body[FRAME_W-1:1]};
    end

    ////////////////////////////////////////////////////////////////////////
    // channel 4 and group one fields

    assign bridge_one_join = cfg4_q[JOIN1_BIT];
    assign peak_hold_one_mask_report = cfg4_q[PHMASK_BIT];
    assign peak_hold_one_enable = cfg4_q[PHEN_BIT];
    assign ch4_diag_filter = cfg4_q[DIAG_HI:DIAG_LO];
    // filter field is ignored while bridge one uses bridge timers
    assign ch4_diag_filter_used = ~(cfg4_q[JOIN1_BIT] & ~bridge_one_timer_extend);
    assign ch4_threshold_readback_select = cfg4_q[RDSEL_BIT];
    assign ch4_overcurrent_threshold = cfg4_q[THR_HI:THR_LO];
    assign ch4_thermal_compensation = cfg4_q[TCOMP_HI:TCOMP_LO];
    assign ch4_supply_compensation = cfg4_q[VCOMP_BIT];
    assign ch4_overcurrent_blanking = cfg4_q[BLANK_HI:BLANK_LO];
    // bridge operation forces readout-then-switch re-engagement
    assign ch4_reengage_policy = cfg4_q[REENG_BIT] | cfg4_q[JOIN1_BIT];
    assign ch4_sense_method = cfg4_q[SENSE_BIT];
    assign ch4_ol_current_high = cfg4_q[OLCUR_BIT];
    assign ch4_gate_current = cfg4_q[GATE_HI:GATE_LO];
    // transistor type only matters on the high side
    assign ch4_pmos_select = cfg4_q[SIDE_BIT] & cfg4_q[PMOS_BIT];
    assign ch4_side_select = cfg4_q[SIDE_BIT];
    assign ch4_out_enable = cfg4_q[EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // channel 5 and bridge two fields

    assign bridge_two_deadband = cfg5_q[DEAD_HI:DEAD_LO];
    assign bridge_two_timer_extend = cfg5_q[EXT2_BIT];
    // timer options only apply while bridge two is joined
    assign ch6_8_share_ch5_timer = bridge_two_join & ~cfg5_q[EXT2_BIT];
    assign ch5_diag_bridge_table = bridge_two_join & ~cfg5_q[EXT2_BIT];
    assign ch5_diag_filter = cfg5_q[DIAG_HI:DIAG_LO];
    assign ch5_threshold_readback_select = cfg5_q[RDSEL_BIT];
    assign ch5_overcurrent_threshold = cfg5_q[THR_HI:THR_LO];
    assign ch5_thermal_compensation = cfg5_q[TCOMP_HI:TCOMP_LO];
    assign ch5_supply_compensation = cfg5_q[VCOMP_BIT];
    assign ch5_overcurrent_blanking = cfg5_q[BLANK_HI:BLANK_LO];
    assign ch5_reengage_policy = cfg5_q[REENG_BIT] | bridge_two_join;
    assign ch5_sense_method = cfg5_q[SENSE_BIT];
    assign ch5_ol_current_high = cfg5_q[OLCUR_BIT];
    assign ch5_gate_current = cfg5_q[GATE_HI:GATE_LO];
    assign ch5_pmos_select = cfg5_q[SIDE_BIT] & cfg5_q[PMOS_BIT];
    assign ch5_side_select = cfg5_q[SIDE_BIT];
    assign ch5_out_enable = cfg5_q[EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // status

    assign comm_error = err_q;
    assign frame_strobe = strobe_q;
endmodule
`default_nettype wire

/* File: logic/ccf_pkg.sv */
// constants and field layout of the channel 4 and channel 5 configuration frames
package ccf_pkg;

    // frame geometry
    localparam int FRAME_W = 32;
    localparam int CNT_W = 5;

    // command codes of the two frames handled here
    typedef enum logic [3:0] {
        CCF_CMD_OUT4 = 4'h4,
        CCF_CMD_OUT5 = 4'h5
    } ccf_cmd_t;

    // common field positions
    localparam int CMD_HI = 31;
    localparam int CMD_LO = 28;
    localparam int RW_BIT = 27;
    localparam int DIAG_HI = 23;
    localparam int DIAG_LO = 22;
    localparam int RDSEL_BIT = 21;
    localparam int THR_HI = 20;
    localparam int THR_LO = 15;
    localparam int TCOMP_HI = 14;
    localparam int TCOMP_LO = 13;
    localparam int VCOMP_BIT = 12;
    localparam int BLANK_HI = 11;
    localparam int BLANK_LO = 9;
    localparam int REENG_BIT = 8;
    localparam int SENSE_BIT = 7;
    localparam int OLCUR_BIT = 6;
    localparam int GATE_HI = 5;
    localparam int GATE_LO = 4;
    localparam int PMOS_BIT = 3;
    localparam int SIDE_BIT = 2;
    localparam int EN_BIT = 1;
    localparam int PAR_BIT = 0;

    // fields only in the command 4 frame
    localparam int JOIN1_BIT = 26;
    localparam int PHMASK_BIT = 25;
    localparam int PHEN_BIT = 24;

    // fields only in the command 5 frame
    localparam int DEAD_HI = 26;
    localparam int DEAD_LO = 25;
    localparam int EXT2_BIT = 24;

    // stored span of a frame and field widths
    localparam int CFG_HI = 26;
    localparam int CFG_LO = 1;
    localparam int THR_W = 6;
    localparam int BLANK_W = 3;
    localparam int TWO_W = 2;

    // reset value of both stored frames: all outputs off, low side
    localparam logic [FRAME_W-1:0] CFG_RESET = 32'h0000_0000;

endpackage

/* File: logic/ccf_spi_shift.sv */
// serial shifter on the link clock: frame capture and reply shift-out
`timescale 1ns/10ps
`default_nettype none
module ccf_spi_shift
    import ccf_pkg::*;
#(
    parameter int FRAME_BITS = 32
) (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic [ccf_pkg::FRAME_W-1:0] reply_word,
    output logic [ccf_pkg::FRAME_W-1:0] rx_word,
    output logic frame_full,
    output logic miso_o,
    output logic miso_oe_n
);
    logic [CNT_W-1:0] cnt_q;
    logic [FRAME_W-1:0] rx_sh_q;
    logic [FRAME_W-1:0] tx_q;
    logic [FRAME_W-1:0] rx_word_q;
    logic full_q;
    logic miso_q;

    // the counter width only serves a 32-bit frame
    if (FRAME_BITS != FRAME_W) begin : g_bad_width
        $error("ccf_spi_shift serves 32-bit frames only");
    end

    // bit count and done flag end with the frame select
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= '0;
            full_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == CNT_W'(FRAME_W - 1))
                full_q <= 1'b1;
        end
    end

    // input shift and word capture on the 32nd rising edge
    always_ff @(posedge sclk) begin
        rx_sh_q <= {rx_sh_q[FRAME_W-2:0], mosi};
        if (!full_q && cnt_q == CNT_W'(FRAME_W - 1))
            rx_word_q <= {rx_sh_q[FRAME_W-2:0], mosi};
    end

    // reply is sampled at the first edge, then shifted msb first
    always_ff @(posedge sclk) begin
        if (cnt_q == '0)
            tx_q <= {reply_word[FRAME_W-2:0], 1'b0};
        else
            tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
    end

    // output bit changes on the falling edge
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n)
            miso_q <= 1'b0;
        else
            miso_q <= tx_q[FRAME_W-1];
    end

    assign miso_o = (cnt_q == '0) ? reply_word[FRAME_W-1] : miso_q;
    assign miso_oe_n = cs_n; // drive only while selected
    assign rx_word = rx_word_q;
    assign frame_full = full_q;
endmodule
`default_nettype wire

/* File: verification/ccf_channel_config_props.sv */
// checker for the channel 4 and 5 configuration block
`timescale 1ns/10ps
`default_nettype none
module ccf_channel_config_props
    import ccf_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic miso_oe_n,
    input wire logic bridge_one_timer_extend,
    input wire logic bridge_two_join,
    input wire logic bridge_one_join,
    input wire logic ch4_diag_filter_used,
    input wire logic ch4_reengage_policy,
    input wire logic ch5_reengage_policy,
    input wire logic ch4_side_select,
    input wire logic ch4_pmos_select,
    input wire logic bridge_two_timer_extend,
    input wire logic ch5_diag_bridge_table,
    input wire logic ch6_8_share_ch5_timer,
    input wire logic [ccf_pkg::THR_W-1:0] ch4_overcurrent_threshold,
    input wire logic [ccf_pkg::THR_W-1:0] ch5_overcurrent_threshold,
    input wire logic comm_error,
    input wire logic frame_strobe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // stored fields that only a frame may change
    wire logic [12:0] held = {bridge_one_join, ch4_overcurrent_threshold,
        ch5_overcurrent_threshold};
    ////////////////////////////////////////
    sequence s_quiet;
        !frame_strobe [*8];
    endsequence
    property p_strobe_pulse;
        frame_strobe |=> s_quiet;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    property p_store_strobe;
        !$stable(held) |-> frame_strobe;
    endproperty
    a_store_strobe: assert property (p_store_strobe) else $error("change without frame");
    property p_err_keep;
        frame_strobe && comm_error |-> $past(held, 2) == held;
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("refused frame stored");
    property p_err_flag;
        $rose(comm_error) |-> frame_strobe;
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag off frame");
    property p_filter;
        ch4_diag_filter_used == !(bridge_one_join && !bridge_one_timer_extend);
    endproperty
    a_filter: assert property (p_filter) else $error("filter use wrong");
    property p_reeng;
        (bridge_one_join |-> ch4_reengage_policy) and (bridge_two_join |-> ch5_reengage_policy);
    endproperty
    a_reeng: assert property (p_reeng) else $error("bridge reengage wrong");
    property p_pmos;
        ch4_pmos_select |-> ch4_side_select;
    endproperty
    a_pmos: assert property (p_pmos) else $error("pmos on low side");
    property p_share;
        ch6_8_share_ch5_timer == (bridge_two_join && !bridge_two_timer_extend)
            && ch5_diag_bridge_table == ch6_8_share_ch5_timer;
    endproperty
    a_share: assert property (p_share) else $error("timer share wrong");
    property p_oe;
        miso_oe_n == cs_n;
    endproperty
    a_oe: assert property (p_oe) else $error("reply enable wrong");
endmodule
bind ccf_channel_config ccf_channel_config_props chk (.*);
`default_nettype wire

/* File: verification/ccf_spi_master.sv */
// link master model: drives the frame pins, captures the reply
`timescale 1ns/10ps
`default_nettype none
module ccf_spi_master (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    ////////////////////////////////////////
    // idle link: clock parked low, deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // one frame of n bits, msb first, 15 ns link clock
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h0000_0000;
        cs_n = 1'b0;
        for (int k = 31; k > 31 - n; k--) begin
            mosi = w[k];
            #7.5 sclk = 1'b1;
            r = {r[30:0], miso};
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        mosi = ~mosi; // no stale level once released
    endtask
endmodule
`default_nettype wire

/* File: verification/channel_config_frames_test.sv */
// self-checking bench for the channel 4 and 5 configuration frames
`timescale 1ns/10ps
`default_nettype none
module channel_config_frames_test;
    import ccf_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, bridge_one_timer_extend = 1'b0, bridge_two_join = 1'b0;
    logic [5:0] ch4_actual_threshold = 6'h00, ch5_actual_threshold = 6'h00;
    logic miso_hold = 1'b0;
    wire logic sclk, cs_n, mosi, miso_o, miso_oe_n;
    wire logic bridge_one_join, peak_hold_one_mask_report, peak_hold_one_enable;
    wire logic ch4_diag_filter_used, ch4_threshold_readback_select, ch4_supply_compensation;
    wire logic ch4_reengage_policy, ch4_sense_method, ch4_ol_current_high, ch4_pmos_select;
    wire logic ch4_side_select, ch4_out_enable, bridge_two_timer_extend, ch5_diag_bridge_table;
    wire logic ch6_8_share_ch5_timer, ch5_threshold_readback_select, ch5_supply_compensation;
    wire logic ch5_reengage_policy, ch5_sense_method, ch5_ol_current_high, ch5_pmos_select;
    wire logic ch5_side_select, ch5_out_enable, comm_error, frame_strobe;
    wire logic [1:0] ch4_diag_filter, ch4_thermal_compensation, ch4_gate_current;
    wire logic [1:0] bridge_two_deadband, ch5_diag_filter, ch5_thermal_compensation;
    wire logic [1:0] ch5_gate_current;
    wire logic [5:0] ch4_overcurrent_threshold, ch5_overcurrent_threshold;
    wire logic [2:0] ch4_overcurrent_blanking, ch5_overcurrent_blanking;
    // released reply line shows the inverse of its last level
    wire logic miso = miso_oe_n ? miso_hold : miso_o;
    wire logic [52:0] snap = {comm_error, bridge_one_join, peak_hold_one_mask_report,
        peak_hold_one_enable, ch4_diag_filter, ch4_threshold_readback_select,
        ch4_overcurrent_threshold, ch4_thermal_compensation, ch4_supply_compensation,
        ch4_overcurrent_blanking, ch4_reengage_policy, ch4_sense_method, ch4_ol_current_high,
        ch4_gate_current, ch4_pmos_select, ch4_side_select, ch4_out_enable,
        bridge_two_deadband, bridge_two_timer_extend, ch5_diag_filter,
        ch5_threshold_readback_select, ch5_overcurrent_threshold, ch5_thermal_compensation,
        ch5_supply_compensation, ch5_overcurrent_blanking, ch5_reengage_policy,
        ch5_sense_method, ch5_ol_current_high, ch5_gate_current, ch5_pmos_select,
        ch5_side_select, ch5_out_enable};
    logic [25:0] c4, c5;
    logic err;
    logic [31:0] rep, rnd;
    logic [52:0] notes[$];
    int miscompares = 0, comparisons = 0;
    ccf_channel_config uut (.*);
    ccf_spi_master host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    ////////////////////////////////////////
    // system clock, 100 MHz
    always #5 mclk = ~mclk;
    always @(miso_o) if (!miso_oe_n) miso_hold = ~miso_o;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected outputs from the stored model words
    function automatic logic [52:0] expv();
        logic [25:0] e4, e5;
        e4 = c4;
        e4[7] = c4[7] | c4[25];
        e4[2] = c4[2] & c4[1];
        e5 = c5;
        e5[7] = c5[7] | bridge_two_join;
        e5[2] = c5[2] & c5[1];
        return {err, e4, e5};
    endfunction
    task automatic report(input logic ok, input string what);
        comparisons++;
        if (!ok) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_reply(input logic [31:0] got, input logic [31:0] exp);
        report(got === exp, "reply word");
    endtask
    task automatic chk_cfg(input logic [52:0] got, input logic [52:0] exp);
        report(got === exp, "stored settings");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // reference decode of one whole frame
    task automatic model(input logic [31:0] w);
        logic [25:0] b;
        b = 26'h0;
        if (^w !== 1'b1) begin
            err = 1'b1;
            rep = 32'h0800_0000;
        end else begin
            err = 1'b0;
            if (!w[27] && w[31:28] == 4'h4) c4 = w[26:1];
            if (!w[27] && w[31:28] == 4'h5) c5 = w[26:1];
            if (w[31:28] == 4'h4) b = c4;
            if (w[31:28] == 4'h5) b = c5;
            if (b[20]) b[19:14] = w[28] ? ch5_actual_threshold : ch4_actual_threshold;
            rep = {w[31:28], 1'b0, b, ~^{w[31:28], b}};
        end
        notes.push_back(expv());
    endtask
    task automatic frame(input logic [31:0] w, input int n);
        logic [31:0] r;
        host.xfer(w, n, r);
        if (n == 32) begin
            chk_reply(r, rep);
            model(w);
            for (int k = 0; k < 12 && frame_strobe !== 1'b1; k++) @(negedge mclk);
            if (frame_strobe !== 1'b1) report(1'b0, "no frame strobe");
        end
        repeat (6) @(posedge mclk);
    endtask
    task automatic reset_dut(input int n);
        sys_rst <= 1'b1;
        repeat (n) @(posedge mclk);
        sys_rst <= 1'b0;
        {c4, c5, err} = 53'h0;
        rep = 32'h0000_0001;
        repeat (2) @(negedge mclk);
        chk_cfg(snap, expv());
    endtask
    // result watcher: each strobe takes the oldest note
    always @(posedge mclk) begin
        if (!sys_rst && frame_strobe === 1'b1) begin
            if (notes.size() == 0) report(1'b0, "unexpected strobe");
            else chk_cfg(snap, notes.pop_front());
        end
    end
    // main sequence
    initial begin
        logic [31:0] w;
        logic [3:0] cmd;
        rnd = 32'h4073_a137;
        reset_dut(12);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            rnd = lfsr(rnd);
            bridge_two_join <= rnd[31];
            bridge_one_timer_extend <= rnd[30];
            ch4_actual_threshold <= rnd[13:8];
            ch5_actual_threshold <= rnd[11:6];
            cmd = (i % 9 == 8) ? 4'h9 : (i[0] ? 4'h5 : 4'h4);
            w = {cmd, i % 5 == 4, rnd[25:0], 1'b0};
            w[0] = ~^w[31:1] ^ (i % 7 == 6);
            frame(w, (i % 11 == 10) ? 16 : 32);
            $display("frame %0d done", i);
        end
        reset_dut(4);
        frame(32'h4000_0000, 32);
        $display("reset test done");
        tally_and_finish();
    end
    // watchdog
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
